// [hdl/pbsp_core.sv]
// pipelined burst static memory port: registered inputs, two-bit burst
// counter, self-timed byte writes, registered read data through a buffer
// assumes the other party meets setup to I_CORE_CLK on all synchronous pins
module pbsp_core
    import pbsp_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES  = LANES_DEF
) (
    input  wire logic                      I_CORE_CLK,
    input  wire logic                      I_RESET,
    input  wire logic [ADDR_W-1:0]         I_ADDR,
    input  wire logic                      I_PROC_ADDR_STROBE_N,
    input  wire logic                      I_CTRL_ADDR_STROBE_N,
    input  wire logic                      I_BURST_ADVANCE_N,
    input  wire logic                      I_PIPELINED_SELECT_N,
    input  wire logic                      I_DEPTH_SELECT_HI,
    input  wire logic                      I_DEPTH_SELECT_LO_N,
    input  wire logic [LANES-1:0]          I_BYTE_LANE_WRITE_N,
    input  wire logic                      I_BYTE_WRITE_GATE_N,
    input  wire logic                      I_ALL_BYTE_WRITE_N,
    input  wire logic                      I_OUTPUT_ENABLE_N,
    input  wire logic                      I_SLEEP_REQUEST,
    input  wire logic                      I_MODE_INTERLEAVED,
    input  wire logic [LANES*LANE_W-1:0]   I_DQ,
    output logic      [LANES*LANE_W-1:0]   O_DQ,
    output logic                           O_DQ_OE,
    output logic                           O_RD_VALID,
    input  wire logic                      I_RD_READY
);
    localparam int DW = LANES * LANE_W;

    // next burst offset in the selected order
    function automatic logic [1:0] pbsp_step(input logic [1:0] cur,
                                            input logic [1:0] start,
                                            input logic       intl);
        logic [1:0] nxt;
        nxt = 2'h0;
        if (intl) begin
            nxt = (((cur ^ start) + 2'h1) & 2'h3) ^ start;
        end else begin
            nxt = cur + 2'h1;
        end
        return nxt;
    endfunction

    typedef struct packed {
        // input stage
        logic [ADDR_W-1:0] addr;
        logic              ps_n, cs_n, adv_n, ce1_n, ce2, ce3_n;
        logic [LANES-1:0]  bw_n;
        logic              bwe_n, gw_n, mode;
        logic [DW-1:0]     din;
        // access state
        logic [ADDR_W-1:0] base;
        logic [1:0]        start, cnt;
        logic              sel;
        // array read pipeline
        logic              rd_v;
        logic [DW-1:0]     rd_d;
        // two-entry output buffer
        logic [DW-1:0]     b0, b1;
        logic [1:0]        bcnt;
    } pbsp_state_t;

    pbsp_state_t st_reg;
    pbsp_state_t st_next;
    logic [DW-1:0] mem [0:(1<<ADDR_W)-1];

    logic              go;
    logic              sel_now;
    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [2:0]        occ;
    logic              wr_en;
    logic [LANES-1:0]  lane_we;
    logic              pop;

    // access decode on the registered pins
    always_comb begin
        go       = !st_reg.ps_n || !st_reg.cs_n;
        // a strobe cycle decides selection at once, so deselect costs no dead cycle
        sel_now  = go ? (!st_reg.ce1_n && st_reg.ce2 && !st_reg.ce3_n)
                      : st_reg.sel;
        cur_addr = {st_reg.base[ADDR_W-1:2], st_reg.cnt};
        // first write beat lands at the address captured with the strobe
        wr_addr  = go ? st_reg.addr : cur_addr;
        lane_we  = '0;
        for (int i = 0; i < LANES; i++) begin
            lane_we[i] = !st_reg.gw_n ||
                         (!st_reg.bwe_n && !st_reg.bw_n[i]);
        end
        // processor strobe start is a read; writes start on controller strobe or later
        wr_en = sel_now && !(go && !st_reg.ps_n) && !I_SLEEP_REQUEST && (|lane_we);
        pop   = (st_reg.bcnt != 2'h0) && I_RD_READY;
        // beats held plus the one in flight, so the buffer never overflows
        occ   = {1'b0, st_reg.bcnt} + {2'b00, st_reg.rd_v};
    end

    // next state of the whole port
    always_comb begin
        st_next = st_reg;
        // register every synchronous pin except I_RD_READY, which pop uses unregistered
        st_next.addr  = I_ADDR;
        st_next.ps_n  = I_PROC_ADDR_STROBE_N;
        st_next.cs_n  = I_CTRL_ADDR_STROBE_N;
        st_next.adv_n = I_BURST_ADVANCE_N;
        st_next.ce1_n = I_PIPELINED_SELECT_N;
        st_next.ce2   = I_DEPTH_SELECT_HI;
        st_next.ce3_n = I_DEPTH_SELECT_LO_N;
        st_next.bw_n  = I_BYTE_LANE_WRITE_N;
        st_next.bwe_n = I_BYTE_WRITE_GATE_N;
        st_next.gw_n  = I_ALL_BYTE_WRITE_N;
        st_next.mode  = I_MODE_INTERLEAVED;
        st_next.din   = I_DQ;
        // address load or burst step
        if (go) begin
            st_next.sel   = sel_now;
            st_next.base  = st_reg.addr;
            st_next.start = st_reg.addr[1:0];
            st_next.cnt   = st_reg.addr[1:0];
        end else if (!st_reg.adv_n && st_reg.sel) begin
            st_next.cnt = pbsp_step(st_reg.cnt, st_reg.start,
                                    st_reg.mode == PBSP_INTERLEAVED);
        end
        // read stage: one beat per selected non-strobe cycle with no write, no sleep and room in the buffer
        st_next.rd_v = st_reg.sel && !go && !wr_en && !I_SLEEP_REQUEST &&
                       (occ < 3'h2 || (occ == 3'h2 && pop));
        st_next.rd_d = mem[cur_addr];
        // buffer keeps beats the receiver stalls on
        case ({st_reg.rd_v, pop})
            2'b10: begin
                if (st_reg.bcnt == 2'h0) st_next.b0 = st_reg.rd_d;
                else st_next.b1 = st_reg.rd_d;
                st_next.bcnt = st_reg.bcnt + 2'h1;
            end
            2'b01: begin
                st_next.b0   = st_reg.b1;
                st_next.bcnt = st_reg.bcnt - 2'h1;
            end
            2'b11: begin
                if (st_reg.bcnt == 2'h1) st_next.b0 = st_reg.rd_d;
                else begin
                    st_next.b0 = st_reg.b1;
                    st_next.b1 = st_reg.rd_d;
                end
            end
            default: begin
                st_next.bcnt = st_reg.bcnt;
            end
        endcase
        if (I_RESET) begin
            st_next.sel  = 1'b0;
            st_next.rd_v = 1'b0;
            st_next.bcnt = DATA_CNT_RST;
            st_next.cnt  = BURST_BITS_RST;
            st_next.ps_n = 1'b1;
            st_next.cs_n = 1'b1;
            st_next.ce1_n = 1'b1;
        end
    end

    // state register
    always_ff @(posedge I_CORE_CLK) begin
        st_reg <= st_next;
    end

    // self-timed array write with lane masks
    always_ff @(posedge I_CORE_CLK) begin
        if (wr_en) begin
            for (int i = 0; i < LANES; i++) begin
                if (lane_we[i]) begin
                    mem[wr_addr][i*LANE_W +: LANE_W] <= st_reg.din[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // pins: asynchronous enable and sleep gate the driver
    always_comb begin
        O_DQ       = st_reg.b0;
        O_RD_VALID = st_reg.bcnt != 2'h0;
        O_DQ_OE    = !I_OUTPUT_ENABLE_N && !I_SLEEP_REQUEST &&
                     (st_reg.bcnt != 2'h0);
    end
endmodule // pbsp_core

// [hdl/pbsp_pkg.sv]
// package for the pipelined burst static memory port
// assumes one core clock and a synchronous active-high reset
package pbsp_pkg;
    localparam int ADDR_W_DEF  = 10;
    localparam int LANES_DEF   = 4;
    localparam int LANE_W      = 8;
    // read latency from address beat to data on the pins
    localparam int FIRST_BEAT_CYCLES = 3;
    localparam logic [1:0] BURST_BITS_RST = 2'h0;
    localparam logic [1:0] DATA_CNT_RST   = 2'h0;
    typedef enum logic {PBSP_LINEAR, PBSP_INTERLEAVED} pbsp_order_t;
endpackage : pbsp_pkg

// [bench/pbsp_monitor.sv]
// checker of the memory port, watching the top ports only
// assumes bind into pbsp_core, one clock, reset high
module pbsp_monitor #(parameter int LANES = 4) (
    input wire logic               I_CORE_CLK,
    input wire logic               I_RESET,
    input wire logic               I_PROC_ADDR_STROBE_N,
    input wire logic               I_CTRL_ADDR_STROBE_N,
    input wire logic               I_PIPELINED_SELECT_N,
    input wire logic               I_ALL_BYTE_WRITE_N,
    input wire logic               I_OUTPUT_ENABLE_N,
    input wire logic               I_SLEEP_REQUEST,
    input wire logic               I_RD_READY,
    input wire logic [LANES*8-1:0] O_DQ,
    input wire logic               O_DQ_OE,
    input wire logic               O_RD_VALID
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    // start of a read on an empty buffer, then three quiet cycles
    sequence s_read;
        !I_PROC_ADDR_STROBE_N && !I_SLEEP_REQUEST && !O_RD_VALID;
    endsequence
    sequence s_quiet;
        (I_PROC_ADDR_STROBE_N && I_CTRL_ADDR_STROBE_N) [*3];
    endsequence
    a_first_beat: assert property (s_read ##0 !I_PIPELINED_SELECT_N ##1 s_quiet |=> O_RD_VALID)
        else $error("first beat late");
    a_desel_quiet: assert property (s_read ##0 I_PIPELINED_SELECT_N ##1 s_quiet |=> !O_RD_VALID)
        else $error("deselected read gave data");
    a_write_quiet: assert property (!I_CTRL_ADDR_STROBE_N && !I_ALL_BYTE_WRITE_N
        && !O_RD_VALID ##1 (!I_PROC_ADDR_STROBE_N && I_PIPELINED_SELECT_N)
        ##1 s_quiet |=> !O_RD_VALID) else $error("write gave data");
    a_hold_beat: assert property (O_RD_VALID && !I_RD_READY |=> O_RD_VALID && $stable(O_DQ))
        else $error("held beat changed");
    a_reset_empty: assert property ($fell(I_RESET) |-> !O_RD_VALID)
        else $error("beat after reset");
    a_oe_off: assert property (I_OUTPUT_ENABLE_N |-> !O_DQ_OE)
        else $error("pins driven while disabled");
    a_sleep_off: assert property (I_SLEEP_REQUEST |-> !O_DQ_OE)
        else $error("pins driven in sleep");
    a_oe_on: assert property (!I_OUTPUT_ENABLE_N && !I_SLEEP_REQUEST && O_RD_VALID |-> O_DQ_OE)
        else $error("pins not driven");
endmodule // pbsp_monitor

bind pbsp_core pbsp_monitor #(.LANES(LANES)) u_monitor (.*);

// [bench/pbsp_sink.sv]
// receiver of read beats, keeps what it takes, stalls on command
// assumes valid and data change just after the clock edge
module pbsp_sink (
    input  wire logic        clk,
    input  wire logic        stall,
    input  wire logic        valid,
    input  wire logic [31:0] data,
    output logic             ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] got[$];
    initial ready = 1'h0;
    // ready follows !stall one edge later, words taken at the edge
    always @(posedge clk) begin
        ready <= !stall;
        if (valid && ready) got.push_back(data);
    end
endmodule // pbsp_sink

// [bench/testbench.sv]
// self-checking bench of the burst memory port
// assumes pbsp_core with 10 address bits and four lanes
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, ps_n = 1, cs_n = 1, adv_n = 1, sel_n = 0, gate_n = 1;
    logic all_n = 1, oe_n = 0, zz = 0, intl = 0, stall = 0, rdy, oe, vld;
    logic [3:0] lane_n = '1;
    logic [9:0] addr = '0;
    logic [31:0] dq = '0, odq;
    int errors = 0, n_compared = 0;
    always #2.5 clk = !clk;
    pbsp_core #(.ADDR_W(10), .LANES(4)) u_dut (.I_CORE_CLK(clk), .I_RESET(rst),
        .I_ADDR(addr), .I_PROC_ADDR_STROBE_N(ps_n), .I_CTRL_ADDR_STROBE_N(cs_n),
        .I_BURST_ADVANCE_N(adv_n), .I_PIPELINED_SELECT_N(sel_n), .I_DEPTH_SELECT_HI(1'h1),
        .I_DEPTH_SELECT_LO_N(1'h0), .I_BYTE_LANE_WRITE_N(lane_n), .I_BYTE_WRITE_GATE_N(gate_n),
        .I_ALL_BYTE_WRITE_N(all_n), .I_OUTPUT_ENABLE_N(oe_n), .I_SLEEP_REQUEST(zz),
        .I_MODE_INTERLEAVED(intl), .I_DQ(dq), .O_DQ(odq), .O_DQ_OE(oe),
        .O_RD_VALID(vld), .I_RD_READY(rdy));
    pbsp_sink u_sink (.clk(clk), .stall(stall), .valid(vld), .data(odq), .ready(rdy));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    // word held at address a once the writes are done
    function automatic logic [31:0] ex(int a);
        return (a == 1) ? 32'h2222_22FF : 32'h1111_1111 * (a + 1);
    endfunction
    task automatic wr(logic [9:0] a, logic [31:0] d, logic [3:0] ln, logic al);
        @(posedge clk);
        {cs_n, addr, dq, lane_n, gate_n, all_n} <= {1'h0, a, d, ln, 1'h0, al};
        @(posedge clk);
        {cs_n, lane_n, gate_n, all_n} <= '1;
        {ps_n, sel_n} <= 2'h1;
        @(posedge clk);
        {ps_n, sel_n} <= 2'h2;
        cyc(3);
    endtask
    // read burst by either strobe, three advances after it
    task automatic rd(logic [9:0] a, logic ctl);
        @(posedge clk);
        {ps_n, cs_n, addr} <= {ctl, !ctl, a};
        @(posedge clk);
        {ps_n, cs_n, adv_n} <= 3'h6;
        cyc(3);
        adv_n <= 1;
        @(posedge clk);
        {ps_n, sel_n} <= 2'h1;
        @(posedge clk);
        {ps_n, sel_n} <= 2'h2;
        cyc(8);
    endtask
    task automatic t_fill();
        for (int a = 0; a < 4; a++) wr(a[9:0], 32'h1111_1111 * (a + 1), '1, 0);
        wr(10'h1, 32'hFFFF_FFFF, 4'hE, 1);
    endtask
    task automatic t_orders();
        for (int m = 0; m < 2; m++) begin
            intl <= m[0];
            u_sink.got.delete();
            rd(10'h1, 0);
            chk("beats", 4, u_sink.got.size());
            for (int i = 0; i < 4; i++) chk("beat", ex(m ? 1 ^ i : (1 + i) & 3), u_sink.got[i]);
        end
    endtask
    task automatic t_stall();
        stall <= 1;
        u_sink.got.delete();
        rd(10'h2, 1);
        chk("full", 1, vld);
        chk("drive", 1, oe);
        oe_n <= 1;
        #1 chk("undriven", 0, oe);
        @(posedge clk);
        {oe_n, zz} <= 2'h1;
        #1 chk("asleep", 0, oe);
        @(posedge clk);
        {oe_n, zz, stall} <= 3'h0;
        cyc(6);
        chk("kept", 2, u_sink.got.size());
        chk("w0", ex(2), u_sink.got[0]);
        chk("w1", ex(3), u_sink.got[1]);
    endtask
    task automatic t_quiet();
        u_sink.got.delete();
        sel_n <= 1;
        rd(10'h0, 0);
        sel_n <= 0;
        zz <= 1;
        #1 chk("sleep", 0, oe);
        @(posedge clk);
        zz <= 0;
        chk("desel", 0, u_sink.got.size());
    endtask
    task automatic print_verdict();
        if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        cyc(6);
        rst <= 0;
        t_fill();
        t_orders();
        t_stall();
        t_quiet();
        print_verdict();
    end
    // run needs about 105 cycles, so 3000 means a hang
    initial begin
        cyc(3000);
        errors++;
        print_verdict();
    end
endmodule // testbench
